//--- hw/tdc_top.sv
// text display controller: refresh timing, cursor, editing commands
//
// Summary of operation
// - capture command code on strobe rising edge
// - codes 0-3: page erase, eol erase, LF, nop
// - codes 4-7: left, line erase, up, character
// - write pulse during hsync at cursor address
// - after write, refresh address, cursor advances
// - column on low five plus bit five
// - 2 Hz cursor underline and blank phases
// - last column write wraps, scrolls on last line
// - line feed on bottom line scrolls
// - scroll erases top line, shifts up
// - erase uses write pulses, zeros external
// - composite sync high, 64 us period, 4 us
// - page end pulses low 10 us
// - page select flips at page boundary
// - page select low page one, high two
// - addresses change on char clock trailing edge
// - dot clock gate low during retrace
`timescale 1ns/100ps
`include "tdc_map.svh"
module tdc_top
  import tdc_pkg::*;
(
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RSTN,
  // command port from host
  input  wire logic       COMMAND_STROBE,
  input  wire logic [2:0] COMMAND_CODE,
  // character clock from the dot timing
  input  wire logic       CHAR_CLOCK_IN,
  // page memory addressing
  output logic [4:0]      LOW_COLUMN_ADDRESS,
  output logic [4:0]      UPPER_LINE_ADDRESS,
  output logic            WRITE_PULSE,
  // character generator and video
  output logic [2:0]      GLYPH_ROW_ADDRESS,
  output logic            CURSOR_VIDEO_OUT,
  output logic            DOT_CLOCK_GATE,
  output logic            COMPOSITE_SYNC_OUT,
  // page linking
  output logic            PAGE_END_PULSE_N,
  output logic            PAGE_SELECT_OUT,
  // command busy, high while a command runs
  output logic            BUSY
);
  logic          strobe_s;     // synchronised strobe
  logic          strobe_d;     // previous strobe for edge detect
  logic          char_s;       // synchronised character clock
  logic          char_d;       // previous character clock
  logic [2:0]    code_s1;      // code first stage
  logic [2:0]    code_s2;      // code second stage
  logic [11:0]   hcnt;         // cycle within a scan line
  logic [8:0]    vline;        // scan line within frame
  logic [3:0]    grow;         // glyph row within text line
  logic [3:0]    tline;        // text line on screen
  logic [5:0]    rcol;         // refresh column
  logic [3:0]    top;          // memory line shown at top
  logic          page_hi;      // top line lives in the upper page half
  logic [5:0]    ccol;         // cursor column
  logic [3:0]    cline;        // cursor line on screen
  logic [4:0]    blink;        // frame count for blink
  logic          blink_ph;     // cursor phase
  logic [7:0]    eop_cnt;      // page end pulse width counter
  tdc_cmd_type   cmd;          // latched command
  tdc_state_type state;        // command sequencer
  logic [5:0]    wcol;         // column being written
  logic [3:0]    wline;        // memory line being written
  logic [5:0]    wend;         // last column of this erase pass
  logic [3:0]    lines_left;   // page erase lines still to go
  logic          scroll_pend;  // scroll erase of new bottom line pending
  logic          strobe_rise;
  logic          char_fall;
  logic          hsync;
  logic          line_end;
  logic          in_vsync;

  // pin inputs cross into the clock domain first
  tdc_sync2 u_sync_strobe (.CLK(CLK), .RSTN(RSTN), .async_in(COMMAND_STROBE),
                           .sync_out(strobe_s));
  tdc_sync2 u_sync_char (.CLK(CLK), .RSTN(RSTN), .async_in(CHAR_CLOCK_IN),
                         .sync_out(char_s));

  // the code is held long after the strobe, so two stages lose nothing
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      code_s1  <= 3'h0;
      code_s2  <= 3'h0;
      strobe_d <= 1'b0;
      char_d   <= 1'b0;
    end
    else
    begin
      code_s1  <= COMMAND_CODE;
      code_s2  <= code_s1;
      strobe_d <= strobe_s;
      char_d   <= char_s;
    end
  end

  assign strobe_rise = strobe_s & ~strobe_d;
  assign char_fall   = char_d & ~char_s;
  assign line_end    = (hcnt == 12'(`TDC_LINE_CYC - 1));
  assign hsync       = (hcnt < 12'(`TDC_SYNC_CYC));
  assign in_vsync    = (vline >= `TDC_VSYNC_FIRST);

  // horizontal and vertical counters; one scan line is 64 us
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      hcnt  <= 12'h000;
      vline <= 9'h000;
      grow  <= 4'h0;
      tline <= 4'h0;
    end
    else if (line_end)
    begin
      hcnt <= 12'h000;
      if (vline == 9'(`TDC_FRAME_LINES - 1))
      begin
        vline <= 9'h000;
        grow  <= 4'h0;
        tline <= 4'h0;
      end
      else
      begin
        vline <= vline + 9'h001;
        // rows 0..7 carry glyph, two more blank rows, then next line
        if (grow == 4'(`TDC_ROWS_PER_LINE - 1))
        begin
          grow  <= 4'h0;
          tline <= tline + 4'h1;
        end
        else
          grow <= grow + 4'h1;
      end
    end
    else
      hcnt <= hcnt + 12'h001;
  end

  // refresh column steps on the trailing edge of the character clock
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      rcol <= 6'h00;
    else if (line_end)
      rcol <= 6'h00;
    else if (char_fall && !hsync)
      rcol <= rcol + 6'h01;
  end

  // blink phase toggles every 15 frames, about a quarter second
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      blink    <= 5'h00;
      blink_ph <= 1'b0;
    end
    else if (line_end && vline == 9'(`TDC_FRAME_LINES - 1))
    begin
      if (blink == 5'(`TDC_BLINK_FRAMES - 1))
      begin
        blink    <= 5'h00;
        blink_ph <= ~blink_ph;
      end
      else
        blink <= blink + 5'h01;
    end
  end

  // command sequencer: latch, wait for retrace, write, then move cursor
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state       <= TDC_ST_IDLE;
      cmd         <= TDC_CMD_NOP;
      ccol        <= 6'h00;
      cline       <= 4'h0;
      top         <= 4'h0;
      page_hi     <= 1'b0;
      wcol        <= 6'h00;
      wline       <= 4'h0;
      wend        <= 6'h00;
      lines_left  <= 4'h0;
      scroll_pend <= 1'b0;
      eop_cnt     <= 8'h00;
    end
    else
    begin
      if (eop_cnt != 8'h00)
        eop_cnt <= eop_cnt - 8'h01;
      case (state)
        TDC_ST_IDLE:
        begin
          if (strobe_rise)
          begin
            cmd   <= tdc_cmd_type'(code_s2);
            state <= TDC_ST_WAIT;
          end
        end
        TDC_ST_WAIT:
        begin
          // decide on the last cycle of a line, so that a write covers the whole sync time
          if (line_end)
          begin
            state <= TDC_ST_AFTER;
            wline <= cline + top;
            wcol  <= ccol;
            wend  <= `TDC_LAST_COL;
            case (cmd)
              TDC_CMD_PAGE_ERASE:
              begin
                ccol       <= 6'h00;
                cline      <= 4'h0;
                wline      <= top;
                wcol       <= 6'h00;
                lines_left <= `TDC_LAST_LINE;
                state      <= TDC_ST_WRITE;
              end
              TDC_CMD_EOL_ERASE:
              begin
                ccol  <= 6'h00;
                state <= TDC_ST_WRITE;
              end
              TDC_CMD_LINE_FEED:
              begin
                if (cline == `TDC_LAST_LINE)
                begin
                  top         <= top + 4'h1;
                  wline       <= top;
                  wcol        <= 6'h00;
                  scroll_pend <= 1'b1;
                  state       <= TDC_ST_WRITE;
                  if (top == `TDC_LAST_LINE)
                    page_hi <= ~page_hi;
                  eop_cnt <= 8'(`TDC_EOP_CYC);
                end
                else
                  cline <= cline + 4'h1;
              end
              TDC_CMD_LEFT:
                ccol <= ccol - 6'h01;
              TDC_CMD_LINE_ERASE:
              begin
                wcol  <= 6'h00;
                state <= TDC_ST_WRITE;
              end
              TDC_CMD_UP:
                cline <= cline - 4'h1;
              TDC_CMD_CHAR:
              begin
                wend  <= ccol;
                state <= TDC_ST_WRITE;
              end
              default: ;
            endcase
          end
        end
        TDC_ST_WRITE:
        begin
          // one column per retrace; the pulse spans the sync time
          if (hcnt == 12'(`TDC_SYNC_CYC - 1))
          begin
            if (wcol != wend)
              wcol <= wcol + 6'h01;
            else if (lines_left != 4'h0)
            begin
              lines_left <= lines_left - 4'h1;
              wline      <= wline + 4'h1;
              wcol       <= 6'h00;
            end
            else
            begin
              scroll_pend <= 1'b0;
              state       <= TDC_ST_AFTER;
              if (cmd == TDC_CMD_CHAR)
              begin
                if (ccol != `TDC_LAST_COL)
                  ccol <= ccol + 6'h01;
                else
                begin
                  ccol <= 6'h00;
                  if (cline != `TDC_LAST_LINE)
                    cline <= cline + 4'h1;
                  else
                  begin
                    top         <= top + 4'h1;
                    wline       <= top;
                    wcol        <= 6'h00;
                    wend        <= `TDC_LAST_COL;
                    cmd         <= TDC_CMD_LINE_ERASE;
                    scroll_pend <= 1'b1;
                    state       <= TDC_ST_WRITE;
                    eop_cnt     <= 8'(`TDC_EOP_CYC);
                    if (top == `TDC_LAST_LINE)
                      page_hi <= ~page_hi;
                  end
                end
              end
            end
          end
        end
        TDC_ST_AFTER:
          state <= TDC_ST_IDLE;
        default:
          state <= TDC_ST_IDLE;
      endcase
    end
  end

  // registered outputs: address mux, video, sync and page linking
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      LOW_COLUMN_ADDRESS <= 5'h00;
      UPPER_LINE_ADDRESS <= 5'h00;
      WRITE_PULSE        <= 1'b0;
      GLYPH_ROW_ADDRESS  <= 3'h0;
      CURSOR_VIDEO_OUT   <= 1'b0;
      DOT_CLOCK_GATE     <= 1'b0;
      COMPOSITE_SYNC_OUT <= 1'b0;
      PAGE_END_PULSE_N   <= 1'b1;
      PAGE_SELECT_OUT    <= 1'b0;
      BUSY               <= 1'b0;
    end
    else
    begin
      WRITE_PULSE <= (state == TDC_ST_WRITE) && hsync;
      if ((state == TDC_ST_WRITE) && hsync)
      begin
        LOW_COLUMN_ADDRESS <= wcol[4:0];
        UPPER_LINE_ADDRESS <= {wline, wcol[5]};
      end
      else
      begin
        LOW_COLUMN_ADDRESS <= rcol[4:0];
        UPPER_LINE_ADDRESS <= {tline + top, rcol[5]};
      end
      DOT_CLOCK_GATE     <= ~hsync && !in_vsync;
      // sync inverts during vertical sync so the gate AND recovers it
      COMPOSITE_SYNC_OUT <= hsync ^ in_vsync;
      PAGE_END_PULSE_N   <= (eop_cnt == 8'h00);
      // lines past the wrap come from the other page half
      PAGE_SELECT_OUT    <= page_hi ^ ((5'(tline) + 5'(top)) > 5'h0f);
      if (grow > 4'(`TDC_LAST_GLYPH) || !blink_ph && tline == cline && rcol == ccol
          && grow != `TDC_CURSOR_ROW)
        GLYPH_ROW_ADDRESS <= 3'h0;
      else
        GLYPH_ROW_ADDRESS <= grow[2:0];
      CURSOR_VIDEO_OUT <= blink_ph && tline == cline && rcol == ccol
                          && grow == `TDC_CURSOR_ROW;
      BUSY <= (state != TDC_ST_IDLE);
    end
  end
endmodule : tdc_top

//--- include/tdc_map.svh
// timing, geometry and cursor constants for the text display controller
`ifndef TDC_MAP_SVH
`define TDC_MAP_SVH
`define TDC_CLK_NS        50
`define TDC_LINE_NS       64000
`define TDC_SYNC_NS       4000
`define TDC_EOP_NS        10000
`define TDC_LINE_CYC      (`TDC_LINE_NS / `TDC_CLK_NS)
`define TDC_SYNC_CYC      (`TDC_SYNC_NS / `TDC_CLK_NS)
`define TDC_EOP_CYC       (`TDC_EOP_NS / `TDC_CLK_NS)
`define TDC_BLINK_FRAMES  15
`define TDC_ROWS_PER_LINE 10
`define TDC_LAST_GLYPH    4'h7
`define TDC_CURSOR_ROW    4'h7
`define TDC_TEXT_LINES    16
`define TDC_FRAME_LINES   262
`define TDC_VSYNC_FIRST   9'h0f0
`define TDC_LAST_COL      6'h3f
`define TDC_LAST_LINE     4'hf
`endif

//--- include/tdc_pkg.sv
// types for the text display controller
package tdc_pkg;
  typedef enum logic [2:0] {
    TDC_CMD_PAGE_ERASE = 3'h0,
    TDC_CMD_EOL_ERASE  = 3'h1,
    TDC_CMD_LINE_FEED  = 3'h2,
    TDC_CMD_NOP        = 3'h3,
    TDC_CMD_LEFT       = 3'h4,
    TDC_CMD_LINE_ERASE = 3'h5,
    TDC_CMD_UP         = 3'h6,
    TDC_CMD_CHAR       = 3'h7
  } tdc_cmd_type;
  typedef enum logic [1:0] {
    TDC_ST_IDLE  = 2'h0,
    TDC_ST_WAIT  = 2'h1,
    TDC_ST_WRITE = 2'h2,
    TDC_ST_AFTER = 2'h3
  } tdc_state_type;
endpackage : tdc_pkg

//--- hw/tdc_sync2.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module tdc_sync2
(
  // clock and reset
  input  wire logic CLK,
  input  wire logic RSTN,
  // pin side and synchronised side
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta; // first stage, read only by the second stage

  // two stages give the metastable first stage a full cycle to settle
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule : tdc_sync2

//--- testbench/tdc_top_asserts.sv
// pin-level checks on the text display controller
`timescale 1ns/100ps
module tdc_top_asserts
(
  // clock and reset
  input wire logic       CLK,
  input wire logic       RSTN,
  // command side
  input wire logic       COMMAND_STROBE,
  input wire logic [2:0] COMMAND_CODE,
  input wire logic       CHAR_CLOCK_IN,
  // memory side
  input wire logic [4:0] LOW_COLUMN_ADDRESS,
  input wire logic [4:0] UPPER_LINE_ADDRESS,
  input wire logic       WRITE_PULSE,
  // video side
  input wire logic [2:0] GLYPH_ROW_ADDRESS,
  input wire logic       CURSOR_VIDEO_OUT,
  input wire logic       DOT_CLOCK_GATE,
  input wire logic       COMPOSITE_SYNC_OUT,
  // paging and status
  input wire logic       PAGE_END_PULSE_N,
  input wire logic       PAGE_SELECT_OUT,
  input wire logic       BUSY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic [11:0] sync_run;  // high cycles of sync so far
  logic [7:0]  write_run; // high cycles of the write pulse
  logic [8:0]  end_run;   // low cycles of page end
  // run counters; widths cover the longest legal run, no wrap
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
      sync_run <= 12'h000;
    else
      sync_run <= COMPOSITE_SYNC_OUT ? sync_run + 12'h001 : 12'h000;
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
      write_run <= 8'h00;
    else
      write_run <= WRITE_PULSE ? write_run + 8'h01 : 8'h00;
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
      end_run <= 9'h000;
    else
      end_run <= PAGE_END_PULSE_N ? 9'h000 : end_run + 9'h001;
  // vsync lines invert sync, so long high runs are allowed too
  property p_sync_width;
    $fell(COMPOSITE_SYNC_OUT) |-> sync_run == 12'h050 || sync_run >= 12'h44c;
  endproperty
  a_sync_width: assert property (p_sync_width) else $error("sync width");
  property p_write_width;
    $fell(WRITE_PULSE) |-> write_run == 8'h50;
  endproperty
  a_write_width: assert property (p_write_width) else $error("write width");
  property p_write_retrace;
    $rose(WRITE_PULSE) |-> COMPOSITE_SYNC_OUT || !DOT_CLOCK_GATE;
  endproperty
  a_write_retrace: assert property (p_write_retrace) else $error("write out of retrace");
  property p_addr_hold;
    WRITE_PULSE && $past(WRITE_PULSE) |->
      $stable(LOW_COLUMN_ADDRESS) && $stable(UPPER_LINE_ADDRESS);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in write");
  property p_strobe_busy;
    $rose(COMMAND_STROBE) && !BUSY |-> ##[1:8] BUSY;
  endproperty
  a_strobe_busy: assert property (p_strobe_busy) else $error("strobe not taken");
  property p_cursor_row;
    CURSOR_VIDEO_OUT |-> GLYPH_ROW_ADDRESS == 3'h7;
  endproperty
  a_cursor_row: assert property (p_cursor_row) else $error("cursor off row");
  property p_write_busy;
    WRITE_PULSE |-> BUSY;
  endproperty
  a_write_busy: assert property (p_write_busy) else $error("write while idle");
  property p_end_width;
    $rose(PAGE_END_PULSE_N) |-> end_run == 9'h0c8;
  endproperty
  a_end_width: assert property (p_end_width) else $error("page end width");
  property p_gate_retrace;
    $rose(COMPOSITE_SYNC_OUT) |-> !DOT_CLOCK_GATE;
  endproperty
  a_gate_retrace: assert property (p_gate_retrace) else $error("dot gate in retrace");
endmodule : tdc_top_asserts

bind tdc_top tdc_top_asserts u_chk (.CLK(CLK), .RSTN(RSTN), .COMMAND_STROBE(COMMAND_STROBE),
  .COMMAND_CODE(COMMAND_CODE), .CHAR_CLOCK_IN(CHAR_CLOCK_IN),
  .LOW_COLUMN_ADDRESS(LOW_COLUMN_ADDRESS), .UPPER_LINE_ADDRESS(UPPER_LINE_ADDRESS),
  .WRITE_PULSE(WRITE_PULSE), .GLYPH_ROW_ADDRESS(GLYPH_ROW_ADDRESS),
  .CURSOR_VIDEO_OUT(CURSOR_VIDEO_OUT), .DOT_CLOCK_GATE(DOT_CLOCK_GATE),
  .COMPOSITE_SYNC_OUT(COMPOSITE_SYNC_OUT), .PAGE_END_PULSE_N(PAGE_END_PULSE_N),
  .PAGE_SELECT_OUT(PAGE_SELECT_OUT), .BUSY(BUSY));

//--- testbench/tdc_host_model.sv
// host model that strobes editing commands into the controller
`timescale 1ns/100ps
module tdc_host_model
(
  // clock and status from the controller
  input  wire logic  CLK,
  input  wire logic  BUSY,
  // command pins
  output logic       strobe,
  output logic [2:0] code
);
  int   hold_cnt; // cycles the code must still stand
  int   gap_cnt;  // cycles before the next strobe is allowed
  logic arm;      // one-shot: a strobe just ended
  initial
  begin
    strobe = 1'b0;
    code = 3'h3;
    hold_cnt = 0;
    gap_cnt = 0;
    arm = 1'b0;
  end
  // timers; once the hold runs out the code lines carry junk
  always @(posedge CLK)
  begin
    if (arm)
    begin
      hold_cnt <= 1800; // 90 us code hold
      gap_cnt <= (code == 3'h2 || code == 3'h7) ? 2600 : 1600;
      arm <= 1'b0;
    end
    else
    begin
      if (hold_cnt == 1)
        code <= ~code;
      if (hold_cnt > 0)
        hold_cnt <= hold_cnt - 1;
      if (gap_cnt > 0)
        gap_cnt <= gap_cnt - 1;
    end
  end
  // impatient strobes skip the waits; only a refusal check uses them
  task automatic issue(input logic [2:0] cmd, input bit patient, output bit ok);
    int n;
    n = 0;
    while (patient && (BUSY !== 1'b0 || gap_cnt != 0 || hold_cnt != 0 || arm) && n < 9000)
    begin
      @(negedge CLK);
      n++;
    end
    ok = n < 9000;
    @(posedge CLK);
    code <= cmd;
    repeat (20) @(posedge CLK); // 1 us set-up
    strobe <= 1'b1;
    repeat (10) @(posedge CLK); // 0.5 us width
    strobe <= 1'b0;
    arm <= 1'b1;
  endtask : issue
endmodule : tdc_host_model

//--- testbench/tdc_top_tb.sv
// self-checking bench for the text display controller
`timescale 1ns/100ps
module tdc_top_tb;
  import tdc_pkg::*;
  logic       CLK, RSTN, CHAR_CLOCK_IN, COMMAND_STROBE;
  logic [2:0] COMMAND_CODE, GLYPH_ROW_ADDRESS;
  logic [4:0] LOW_COLUMN_ADDRESS, UPPER_LINE_ADDRESS;
  logic       WRITE_PULSE, CURSOR_VIDEO_OUT, DOT_CLOCK_GATE, COMPOSITE_SYNC_OUT;
  logic       PAGE_END_PULSE_N, PAGE_SELECT_OUT, BUSY;
  logic [2:0] cc_div; // character clock divider
  int         err_count, samples_checked;
  tdc_top DUT (.CLK(CLK), .RSTN(RSTN), .COMMAND_STROBE(COMMAND_STROBE),
    .COMMAND_CODE(COMMAND_CODE), .CHAR_CLOCK_IN(CHAR_CLOCK_IN),
    .LOW_COLUMN_ADDRESS(LOW_COLUMN_ADDRESS), .UPPER_LINE_ADDRESS(UPPER_LINE_ADDRESS),
    .WRITE_PULSE(WRITE_PULSE), .GLYPH_ROW_ADDRESS(GLYPH_ROW_ADDRESS),
    .CURSOR_VIDEO_OUT(CURSOR_VIDEO_OUT), .DOT_CLOCK_GATE(DOT_CLOCK_GATE),
    .COMPOSITE_SYNC_OUT(COMPOSITE_SYNC_OUT), .PAGE_END_PULSE_N(PAGE_END_PULSE_N),
    .PAGE_SELECT_OUT(PAGE_SELECT_OUT), .BUSY(BUSY));
  tdc_host_model host (.CLK(CLK), .BUSY(BUSY), .strobe(COMMAND_STROBE), .code(COMMAND_CODE));
  // 20 MHz system clock
  initial CLK = 1'b0;
  always #25 CLK = ~CLK;
  // one character every 16 clocks: 64 columns fit the visible line
  initial cc_div = 3'h0;
  always @(posedge CLK)
  begin
    cc_div <= cc_div + 3'h1;
    if (cc_div == 3'h7)
      CHAR_CLOCK_IN <= ~CHAR_CLOCK_IN;
  end
  // verdict and end of run
  task automatic end_of_test;
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic pick(input int s);
    return s == 0 ? WRITE_PULSE : s == 1 ? BUSY : COMPOSITE_SYNC_OUT;
  endfunction : pick
  // bounded wait on a falling edge; n is the cycles it took
  task automatic wait_sig(input int s, input logic lvl, output int n);
    n = 0;
    while (pick(s) !== lvl)
    begin
      @(negedge CLK);
      n++;
      if (n > 4000)
      begin
        err_count++;
        $display("BAD %0t wait ran out", $time);
        end_of_test;
      end
    end
  endtask : wait_sig
  // let the host's hold and gap run out, then start just after a sync pulse,
  // so that a command is never taken and finished inside the strobe window
  task automatic align;
    int n;
    n = 0;
    while ((host.gap_cnt != 0 || host.hold_cnt != 0 || host.arm) && n < 4000)
    begin
      @(negedge CLK);
      n++;
    end
    chk(n < 4000, 1'b1);
    wait_sig(2, 1'b1, n);
    wait_sig(2, 1'b0, n);
  endtask : align
  // any non-writing command, run to completion
  task automatic do_cmd(input tdc_cmd_type c);
    bit ok;
    int n;
    align;
    host.issue(c, 1'b1, ok);
    chk(ok, 1'b1);
    wait_sig(1, 1'b1, n);
    wait_sig(1, 1'b0, n);
  endtask : do_cmd
  // checks the write that follows a character code
  task automatic see_write(input logic [3:0] ln, input logic [5:0] cl);
    int n;
    wait_sig(0, 1'b1, n);
    chk(LOW_COLUMN_ADDRESS, cl[4:0]);
    chk(UPPER_LINE_ADDRESS, {ln, cl[5]});
    chk({COMPOSITE_SYNC_OUT, DOT_CLOCK_GATE}, 2'h2);
    wait_sig(0, 1'b0, n);
    chk(n, 80);
    chk(LOW_COLUMN_ADDRESS, 5'h00);
    wait_sig(1, 1'b0, n);
  endtask : see_write
  task automatic write_char(input logic [3:0] ln, input logic [5:0] cl);
    bit ok;
    align;
    host.issue(TDC_CMD_CHAR, 1'b1, ok);
    chk(ok, 1'b1);
    see_write(ln, cl);
  endtask : write_char
  // sync high 80 cycles out of a 1280 cycle line
  task automatic check_sync;
    int n;
    wait_sig(2, 1'b0, n);
    wait_sig(2, 1'b1, n);
    wait_sig(2, 1'b0, n);
    chk(n, 80);
    wait_sig(2, 1'b1, n);
    chk(n, 1200);
    // cursor sits at line 0 column 0 in its blank phase: row forced low
    chk(GLYPH_ROW_ADDRESS, 3'h0);
    chk({CURSOR_VIDEO_OUT, PAGE_SELECT_OUT}, 2'h0);
  endtask : check_sync
  // a strobe while busy must be dropped, not queued
  task automatic refused_strobe;
    bit ok;
    align;
    host.issue(TDC_CMD_CHAR, 1'b1, ok);
    host.issue(TDC_CMD_LINE_FEED, 1'b0, ok);
    @(negedge CLK);
    chk(BUSY, 1'b1);
    see_write(4'h0, 6'h05);
    write_char(4'h0, 6'h06);
  endtask : refused_strobe
  // main sequence
  initial
  begin
    RSTN = 1'b0;
    CHAR_CLOCK_IN = 1'b0;
    err_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge CLK);
    @(negedge CLK);
    chk({WRITE_PULSE, PAGE_END_PULSE_N, BUSY}, 3'h2);
    @(posedge CLK);
    RSTN <= 1'b1;
    repeat (4) @(posedge CLK);
    check_sync;
    write_char(4'h0, 6'h00);
    write_char(4'h0, 6'h01);
    do_cmd(TDC_CMD_LEFT);
    write_char(4'h0, 6'h01);
    do_cmd(TDC_CMD_LINE_FEED);
    write_char(4'h1, 6'h02);
    do_cmd(TDC_CMD_UP);
    write_char(4'h0, 6'h03);
    do_cmd(TDC_CMD_NOP);
    write_char(4'h0, 6'h04);
    refused_strobe;
    end_of_test;
  end
endmodule : tdc_top_tb
